// >>> src/dpc_pkg.sv
/*
 * Constants, field layout and helpers for the dual data pointer unit.
 * Assumes an 8-bit special-function-register bus and a core that pulses
 * one strobe per pointer-indexed data or code move.
 */
package dpc_pkg;
	// ==========================================================
	// register addresses
	localparam logic [7:0] DPC_ADDR_CTRL = 8'hA7;
	localparam logic [7:0] DPC_ADDR_LOW = 8'h82;
	localparam logic [7:0] DPC_ADDR_HIGH = 8'h83;
	localparam logic [7:0] DPC_ADDR_PAGE = 8'h84;
	// ==========================================================
	// control register layout
	localparam logic [7:0] DPC_CTRL_RESET = 8'h00;
	localparam logic [7:0] DPC_CTRL_WMASK = 8'hFD;
	localparam int DPC_SEL_BIT = 0;
	localparam int DPC_MAIN_MODE_LO = 2;
	localparam int DPC_SHADOW_MODE_LO = 4;
	localparam int DPC_TOGGLE_BIT = 6;
	localparam int DPC_PTR_W = 24;
	localparam logic [23:0] DPC_PTR_RESET = 24'h000000;
	localparam logic [23:0] DPC_ONE = 24'h000001;
	localparam logic [7:0] DPC_READ_IDLE = 8'h00;
	// ==========================================================
	// post-move modes
	typedef enum logic [1:0]
	{
		DPC_MODE_KEEP = 2'h0,
		DPC_MODE_INC = 2'h1,
		DPC_MODE_DEC = 2'h2,
		DPC_MODE_FLIP = 2'h3
	} dpc_mode_t;

	// full-width step, carry runs through all three bytes
	function automatic logic [23:0] dpc_step(input logic [23:0] p,
		input logic up);
		if (up)
			dpc_step = p + DPC_ONE;
		else
			dpc_step = p - DPC_ONE;
	endfunction : dpc_step
endpackage : dpc_pkg

// >>> src/dpc_upd_if.sv
/*
 * Bundle between the pointer unit and its post-move calculator.
 * Assumes both ends sit in the same clock domain; it is purely
 * combinational.
 */
`timescale 1ns/1ps
interface dpc_upd_if;
	import dpc_pkg::*;
	logic [23:0] cur_ptr;
	dpc_mode_t mode;
	logic [23:0] next_ptr;
	modport user (output cur_ptr, output mode, input next_ptr);
	modport calc (input cur_ptr, input mode, output next_ptr);
endinterface : dpc_upd_if

// >>> src/dpc_ptr_step.sv
/*
 * Post-move pointer calculator: keep, step up, step down or flip bit 0.
 * Assumes the caller presents the pointer actually used by the move.
 */
`timescale 1ns/1ps
module dpc_ptr_step
	import dpc_pkg::*;
(
	dpc_upd_if.calc upd
);
	// ==========================================================
	// mode decode
	always_comb
	begin
		case (upd.mode)
			DPC_MODE_KEEP: upd.next_ptr = upd.cur_ptr;
			DPC_MODE_INC: upd.next_ptr = dpc_step(upd.cur_ptr, 1'b1);
			DPC_MODE_DEC: upd.next_ptr = dpc_step(upd.cur_ptr, 1'b0);
			DPC_MODE_FLIP: upd.next_ptr = upd.cur_ptr ^ DPC_ONE;
			default: upd.next_ptr = upd.cur_ptr;
		endcase
	end
endmodule : dpc_ptr_step

// >>> src/dpc_top.sv
/*
 * Dual 24-bit data pointer with control register, post-move modes and
 * automatic pointer swap.
 * Assumes the core drives the register bus and the move strobes
 * synchronously to mclk_i, each strobe high for one enabled cycle.
 */
`timescale 1ns/1ps
module dpc_top
	import dpc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic ptr_move_i,
	input wire logic ptr_load_i,
	input wire logic [23:0] ptr_load_data_i,
	input wire logic ptr_inc_i,
	output logic [23:0] active_pointer_o,
	output logic pointer_select_o
);
	// ==========================================================
	// state
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [23:0] main_q;
	logic [23:0] main_d;
	logic [23:0] shadow_q;
	logic [23:0] shadow_d;
	logic [23:0] act_d;
	logic [7:0] rdata_q;
	logic sel;
	logic [23:0] act;
	logic wr_ctrl;
	logic wr_low;
	logic wr_high;
	logic wr_page;
	dpc_upd_if upd ();

	assign sel = ctrl_q[DPC_SEL_BIT];
	assign wr_ctrl = sfr_wr_i && (sfr_addr_i == DPC_ADDR_CTRL);
	assign wr_low = sfr_wr_i && (sfr_addr_i == DPC_ADDR_LOW);
	assign wr_high = sfr_wr_i && (sfr_addr_i == DPC_ADDR_HIGH);
	assign wr_page = sfr_wr_i && (sfr_addr_i == DPC_ADDR_PAGE);

	// ==========================================================
	// selected pointer and its mode
	assign act = sel ? shadow_q : main_q;
	assign upd.cur_ptr = act;
	assign upd.mode = sel ?
		dpc_mode_t'(ctrl_q[DPC_SHADOW_MODE_LO +: 2]) :
		dpc_mode_t'(ctrl_q[DPC_MAIN_MODE_LO +: 2]);
	assign active_pointer_o = act;
	assign pointer_select_o = sel;

	dpc_ptr_step u_step
	(
		.upd(upd.calc)
	);

	// ==========================================================
	// next value of the selected pointer; byte writes win over core ops
	always_comb
	begin
		act_d = act;
		if (ptr_move_i)
			act_d = upd.next_ptr;
		if (ptr_inc_i)
			act_d = dpc_step(act, 1'b1);
		if (ptr_load_i)
			act_d = ptr_load_data_i;
		if (wr_low)
			act_d[7:0] = sfr_wdata_i;
		if (wr_high)
			act_d[15:8] = sfr_wdata_i;
		if (wr_page)
			act_d[23:16] = sfr_wdata_i;
		main_d = sel ? main_q : act_d;
		shadow_d = sel ? act_d : shadow_q;
	end

	// ==========================================================
	// control next value; a software write beats the auto swap
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (ptr_move_i && ctrl_q[DPC_TOGGLE_BIT])
			ctrl_d[DPC_SEL_BIT] = ~sel;
		if (wr_ctrl)
			ctrl_d = sfr_wdata_i & DPC_CTRL_WMASK;
	end

	// control register, whole-byte access only
	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
			ctrl_q <= DPC_CTRL_RESET;
		else if (ce_i)
			ctrl_q <= ctrl_d;
	end

	// both pointers; only the selected one ever changes
	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			main_q <= DPC_PTR_RESET;
			shadow_q <= DPC_PTR_RESET;
		end
		else if (ce_i)
		begin
			main_q <= main_d;
			shadow_q <= shadow_d;
		end
	end

	// ==========================================================
	// read data, registered one cycle after the strobe
	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
			rdata_q <= DPC_READ_IDLE;
		else if (ce_i && sfr_rd_i)
		begin
			case (sfr_addr_i)
				DPC_ADDR_CTRL: rdata_q <= ctrl_q;
				DPC_ADDR_LOW: rdata_q <= act[7:0];
				DPC_ADDR_HIGH: rdata_q <= act[15:8];
				DPC_ADDR_PAGE: rdata_q <= act[23:16];
				default: rdata_q <= DPC_READ_IDLE; // unmapped reads zero
			endcase
		end
	end
	assign sfr_rdata_o = rdata_q;

	// ==========================================================
	// assertions
	// quiet: no byte write, load or increment outranks the move update
	logic quiet;
	assign quiet = !sfr_wr_i && !ptr_load_i && !ptr_inc_i;

	AST_MAIN_MAP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && sfr_rd_i && !sel && sfr_addr_i == DPC_ADDR_LOW
		|=> sfr_rdata_o == $past(main_q[7:0]))
		else $error("main pointer not mapped");
	AST_SHADOW_MAP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && sfr_rd_i && sel && sfr_addr_i == DPC_ADDR_HIGH
		|=> sfr_rdata_o == $past(shadow_q[15:8]))
		else $error("shadow pointer not mapped");
	AST_TOGGLE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && ptr_move_i && ctrl_q[DPC_TOGGLE_BIT] && !wr_ctrl
		|=> sel != $past(sel))
		else $error("auto toggle missed");
	AST_NO_TOGGLE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && !ctrl_q[DPC_TOGGLE_BIT] && !wr_ctrl |=> $stable(sel))
		else $error("select changed without toggle");
	AST_SHADOW_INC: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && ptr_move_i && quiet && sel
		&& ctrl_q[DPC_SHADOW_MODE_LO +: 2] == 2'h1
		|=> shadow_q == $past(shadow_q) + DPC_ONE && $stable(main_q))
		else $error("shadow post increment wrong");
	AST_MAIN_DEC: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && ptr_move_i && quiet && !sel
		&& ctrl_q[DPC_MAIN_MODE_LO +: 2] == 2'h2
		|=> main_q == $past(main_q) - DPC_ONE && $stable(shadow_q))
		else $error("main post decrement wrong");
	AST_MAIN_FLIP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && ptr_move_i && quiet && !sel
		&& ctrl_q[DPC_MAIN_MODE_LO +: 2] == 2'h3
		|=> main_q == ($past(main_q) ^ DPC_ONE))
		else $error("main bit 0 flip wrong");
	AST_BIT1_ZERO: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		sfr_rd_i && ce_i && sfr_addr_i == DPC_ADDR_CTRL |=> !sfr_rdata_o[1])
		else $error("control bit 1 reads one");
	AST_IDLE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && !ptr_move_i && quiet
		|=> $stable(main_q) && $stable(shadow_q) && $stable(ctrl_q))
		else $error("state changed without a pointer move");
	AST_RESET: assert property (@(posedge mclk_i)
		!rstn_i |=> ctrl_q == DPC_CTRL_RESET)
		else $error("control not reset to zero");
	AST_RSVD_KEEP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && wr_ctrl |=> ctrl_q[7] == $past(sfr_wdata_i[7]))
		else $error("reserved bit not kept");
	AST_LOAD: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && ptr_load_i && !sfr_wr_i && !ptr_move_i
		|=> active_pointer_o == $past(ptr_load_data_i))
		else $error("load missed selected pointer");

	// reset, freeze and the core's own pointer operations
	AST_PTR_RESET: assert property (@(posedge mclk_i)
		!rstn_i |=> main_q == DPC_PTR_RESET && shadow_q == DPC_PTR_RESET
		&& sfr_rdata_o == DPC_READ_IDLE)
		else $error("pointers or read data not reset");
	AST_FROZEN: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!ce_i |=> $stable(main_q) && $stable(shadow_q) && $stable(ctrl_q)
		&& $stable(sfr_rdata_o))
		else $error("state changed while clock enable low");
	AST_INC: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && ptr_inc_i && !sfr_wr_i && !ptr_load_i && !ptr_move_i
		|=> active_pointer_o == $past(active_pointer_o) + DPC_ONE)
		else $error("increment missed selected pointer");
	// byte writes outrank every core operation on the selected pointer
	AST_BYTE_LOW: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && wr_low && !ptr_move_i
		|=> active_pointer_o[7:0] == $past(sfr_wdata_i))
		else $error("low byte write missed selected pointer");

	// ==========================================================
	// coverage of the main scenarios
	COV_SWAP_MOVE: cover property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && ptr_move_i && ctrl_q[DPC_TOGGLE_BIT] ##1 ce_i && ptr_move_i);
	COV_CARRY: cover property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && ptr_move_i && act[15:0] == 16'hFFFF);
	COV_FROZEN: cover property (@(posedge mclk_i) disable iff (!rstn_i)
		!ce_i && ptr_move_i);
	COV_SHADOW_READ: cover property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && sfr_rd_i && sel);
endmodule : dpc_top

// >>> sim/dpc_core_model.sv
/*
 * Core model: issues pointer strobes as the execution unit would.
 * Assumes the unit under test samples strobes on rising mclk_i edges.
 */
`timescale 1ns/1ps
module dpc_core_model
(
	input wire logic mclk_i,
	output logic move_o,
	output logic load_o,
	output logic inc_o,
	output logic [23:0] data_o
);
	// ==========================================================
	// strobes idle low; released data is inverted so stale values
	// cannot pass for fresh ones
	initial
	begin
		move_o = 1'b0;
		load_o = 1'b0;
		inc_o = 1'b0;
		data_o = 24'h000000;
	end

	// k: 1 pointer-indexed move, 2 load, 3 increment; one-cycle pulse
	task automatic op(input logic [1:0] k, input logic [23:0] d);
		@(posedge mclk_i);
		move_o <= (k == 2'h1); // only indexed moves strobe
		load_o <= (k == 2'h2);
		inc_o <= (k == 2'h3);
		data_o <= d;
		@(posedge mclk_i);
		move_o <= 1'b0;
		load_o <= 1'b0;
		inc_o <= 1'b0;
		data_o <= ~d;
		#1;
	endtask : op
endmodule : dpc_core_model

// >>> sim/dpc_top_tb.sv
/*
 * Self-checking bench for the dual pointer unit.
 * Assumes the register bus and core strobe timing of the unit's contract.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module dpc_top_tb;
	import dpc_pkg::*;
	logic mclk_i, rstn_i, ce_i, sfr_wr_i, sfr_rd_i;
	logic [7:0] sfr_addr_i, sfr_wdata_i;
	logic [7:0] sfr_rdata_o;
	logic mv, ld, inc;
	logic [23:0] ldd, ap;
	logic sel;
	int fails = 0;
	int compares = 0;
	logic [23:0] exp_t [4] = '{24'h00FFFF, 24'h010000, 24'h00FFFE,
		24'h00FFFE};

	dpc_top DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
		.sfr_rdata_o(sfr_rdata_o), .ptr_move_i(mv), .ptr_load_i(ld),
		.ptr_load_data_i(ldd), .ptr_inc_i(inc),
		.active_pointer_o(ap), .pointer_select_o(sel));
	dpc_core_model core (.mclk_i(mclk_i), .move_o(mv), .load_o(ld),
		.inc_o(inc), .data_o(ldd));

	// ==========================================================
	// clock and bus tasks
	initial
	begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		sfr_wr_i <= 1'b1;
		@(posedge mclk_i);
		sfr_wr_i <= 1'b0;
		#1;
	endtask : wr

	// read data is registered, so it is checked after the taking edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		sfr_addr_i <= a;
		sfr_rd_i <= 1'b1;
		@(posedge mclk_i);
		sfr_rd_i <= 1'b0;
		#1;
		`CHK(sfr_rdata_o, e)
	endtask : rd

	task automatic summarize;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	// watchdog so a hang still reaches the verdict
	initial
	begin
		repeat (5000) @(posedge mclk_i);
		fails++;
		summarize();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		logic [7:0] c;
		rstn_i = 1'b0;
		ce_i = 1'b1;
		sfr_wr_i = 1'b0;
		sfr_rd_i = 1'b0;
		sfr_addr_i = 8'h00;
		sfr_wdata_i = 8'h00;
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'b1;
		rd(DPC_ADDR_CTRL, 8'h00);
		`CHK(ap, 24'h000000)
		wr(DPC_ADDR_CTRL, 8'hFF);
		rd(DPC_ADDR_CTRL, 8'hFD);
		rd(8'h55, 8'h00);
		wr(DPC_ADDR_CTRL, 8'h00);
		core.op(2'h2, 24'h12FFFF);
		rd(DPC_ADDR_LOW, 8'hFF);
		rd(DPC_ADDR_PAGE, 8'h12);
		wr(DPC_ADDR_CTRL, 8'h01);
		`CHK(ap, 24'h000000)
		core.op(2'h2, 24'hABCDEF);
		core.op(2'h3, 24'h000000);
		rd(DPC_ADDR_HIGH, 8'hCD);
		`CHK(ap, 24'hABCDF0)
		wr(DPC_ADDR_CTRL, 8'h00);
		`CHK(ap, 24'h12FFFF)
		// every mode on the main pointer, then on the shadow one
		for (int i = 0; i < 8; i++)
		begin
			c = i[2] ? {2'b00, i[1:0], 4'b0001} : {4'b0000, i[1:0], 2'b00};
			wr(DPC_ADDR_CTRL, c);
			core.op(2'h2, 24'h00FFFF);
			core.op(2'h1, 24'h000000);
			`CHK(ap, exp_t[i[1:0]])
			`CHK(sel, i[2])
		end
		wr(DPC_ADDR_CTRL, 8'h00);
		`CHK(ap, 24'h00FFFE)
		// auto-toggle: update lands on the used pointer, then swap
		wr(DPC_ADDR_CTRL, 8'h55);
		core.op(2'h2, 24'h00D000);
		core.op(2'h1, 24'h000000);
		`CHK(sel, 1'b0)
		`CHK(ap, 24'h00FFFE)
		core.op(2'h1, 24'h000000);
		`CHK(ap, 24'h00D001)
		core.op(2'h1, 24'h000000);
		`CHK(ap, 24'h00FFFF)
		// bit 1 is masked on write and reads back zero; select stays put
		wr(DPC_ADDR_CTRL, 8'h56);
		rd(DPC_ADDR_CTRL, 8'h54);
		// main increment carries out of the high byte into the page
		wr(DPC_ADDR_CTRL, 8'h04);
		core.op(2'h1, 24'h000000);
		`CHK(sel, 1'b0)
		`CHK(ap, 24'h010000)
		// a frozen enable drops both the write and the move
		@(posedge mclk_i);
		ce_i <= 1'b0;
		wr(DPC_ADDR_CTRL, 8'h01);
		core.op(2'h1, 24'h000000);
		`CHK(sel, 1'b0)
		`CHK(ap, 24'h010000)
		@(posedge mclk_i);
		ce_i <= 1'b1;
		// reset in mid-run returns every register to its start value
		@(posedge mclk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		rstn_i <= 1'b1;
		#1;
		`CHK(sfr_rdata_o, 8'h00)
		`CHK(ap, 24'h000000)
		rd(DPC_ADDR_CTRL, 8'h00);
		// byte writes land on the selected pointer only
		wr(DPC_ADDR_LOW, 8'h34);
		wr(DPC_ADDR_HIGH, 8'h12);
		wr(DPC_ADDR_PAGE, 8'h5A);
		`CHK(ap, 24'h5A1234)
		wr(DPC_ADDR_CTRL, 8'h01);
		wr(DPC_ADDR_LOW, 8'h77);
		`CHK(ap, 24'h000077)
		wr(DPC_ADDR_CTRL, 8'h08);
		`CHK(ap, 24'h5A1234)
		// main decrement borrows through both lower bytes
		wr(DPC_ADDR_LOW, 8'h00);
		wr(DPC_ADDR_HIGH, 8'h00);
		core.op(2'h1, 24'h000000);
		`CHK(ap, 24'h59FFFF)
		`CHK(sel, 1'b0)
		summarize();
	end
endmodule : dpc_top_tb
